/* File: verification/iexu_exec_monitor.sv */
// concurrent checks on the integer execution unit ports
`timescale 1ns/1ns
`include "iexu_defs.vh"
module iexu_exec_monitor (
  input wire        clk,
  input wire        rstn,
  input wire        issue,
  input wire [5:0]  opcode,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [9:0]  reg_number,
  input wire [31:0] result,
  input wire        result_valid,
  input wire [31:0] machine_state,
  input wire [31:0] save_restore_0,
  input wire [31:0] save_restore_1,
  input wire [31:0] vector_prefix,
  input wire [31:0] new_pc,
  input wire        pc_load
);
  reg signed [63:0] prod_q;
  // ----------------------------------------
  // helper logic and assertions
  // ----------------------------------------
  // product held one cycle so the high-word check needs no wide past value
  always @(posedge clk) begin
    prod_q <= $signed(src_a) * $signed(src_b);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_or_result: assert property (
    issue && opcode == `IEXU_OP_OR |=> result_valid && result == ($past(src_a) | $past(src_b)))
    else $error("or result wrong");
  a_mulhw_upper: assert property (
    issue && opcode == `IEXU_OP_MULHW |=> result_valid && result == prod_q[63:32])
    else $error("high word product wrong");
  a_neg_value: assert property (
    issue && opcode == `IEXU_OP_NEG |=> result == ~$past(src_a) + 32'h1)
    else $error("negate wrong");
  a_slw_overrange: assert property (
    issue && opcode == `IEXU_OP_SLW && src_b[5] |=> result_valid && result == 32'h0)
    else $error("left shift not cleared");
  a_mfspr_local: assert property (
    issue && opcode == `IEXU_OP_MFSPR && reg_number == `IEXU_SPR_SAVE_RESTORE_0
    |=> result == $past(save_restore_0)) else $error("special read wrong");
  a_syscall_entry: assert property (
    issue && opcode == `IEXU_OP_SYSCALL |=> pc_load && save_restore_1 == $past(machine_state)
    && new_pc == ({16'h0, `IEXU_SC_OFFSET} | ($past(vector_prefix) & 32'hffff0000)))
    else $error("system call entry wrong");
  a_rfi_return: assert property (
    issue && opcode == `IEXU_OP_RFI |=> pc_load && new_pc == $past(save_restore_0)
    && machine_state == $past(save_restore_1)) else $error("return wrong");
  a_nop_quiet: assert property (
    issue && opcode == `IEXU_OP_NOP |=> !result_valid && !pc_load && $stable(machine_state))
    else $error("no-op changed state");
endmodule

bind iexu_integer_exec_unit iexu_exec_monitor mon_u (
  .clk, .rstn, .issue, .opcode, .src_a, .src_b, .reg_number, .result, .result_valid,
  .machine_state, .save_restore_0, .save_restore_1, .vector_prefix, .new_pc, .pc_load
);

/* File: verification/iexu_integer_exec_unit_test.sv */
// self-checking testbench for the integer execution unit
`timescale 1ns/1ns
`include "iexu_defs.vh"
module iexu_integer_exec_unit_test;
  reg         clk = 1'b0, rstn = 1'b0, issue = 1'b0;
  reg         is_unsigned = 1'b0, record_form = 1'b0, ovf_enable = 1'b0, saturate = 1'b0;
  reg  [5:0]  opcode = 6'h00;
  reg  [31:0] src_a = 32'h0, src_b = 32'h0, src_t = 32'h0, pc_in = 32'h00002000;
  reg  [15:0] immediate = 16'h0, s_imm = 16'h0;
  reg  [4:0]  shift_imm = 5'h0, mask_begin = 5'h0, mask_end = 5'h0;
  reg  [4:0]  s_sh = 5'h0, s_mb = 5'h0, s_me = 5'h0;
  reg  [7:0]  field_mask = 8'h0, s_fm = 8'h0;
  reg  [9:0]  reg_number = 10'h0, s_rn = 10'h0;
  reg  [3:0]  s_fl = 4'h0;
  reg  [63:0] timebase = 64'h0123456789abcdef;
  wire [31:0] spr_rdata, result, cond_reg, fixed_exception_reg, machine_state;
  wire [31:0] save_restore_0, save_restore_1, save_restore_2, save_restore_3;
  wire [31:0] vector_prefix, new_pc, spr_wdata, dcr_wdata, rf_target;
  wire [9:0]  spr_number, dcr_number;
  wire        result_valid, pc_load, spr_write, dcr_write;
  integer     errors = 0, compares = 0;

  iexu_integer_exec_unit dut_u (
    .clk, .rstn, .issue, .opcode, .is_unsigned, .record_form, .ovf_enable, .saturate,
    .src_a, .src_b, .src_t, .immediate, .shift_imm, .mask_begin, .mask_end, .field_mask,
    .reg_number, .pc_in, .spr_rdata, .timebase, .result, .result_valid, .cond_reg,
    .fixed_exception_reg, .machine_state, .save_restore_0, .save_restore_1,
    .save_restore_2, .save_restore_3, .vector_prefix, .new_pc, .pc_load, .spr_wdata,
    .spr_number, .spr_write, .dcr_wdata, .dcr_number, .dcr_write);
  iexu_regfile_model far_u (.clk, .rstn, .result, .result_valid, .spr_wdata, .spr_write,
    .spr_rdata, .target(rf_target));
  // ----------------------------------------
  // clock, drivers and checks
  // ----------------------------------------
  always #4 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one operation with an idle cycle after it, so every pulse is seen alone
  task exec(input [5:0] op, input [31:0] va, input [31:0] vb = 0, input [31:0] vt = 0);
    begin
      @(posedge clk);
      issue <= 1'b1;
      opcode <= op;
      {src_a, src_b, src_t} <= {va, vb, vt};
      {is_unsigned, record_form, ovf_enable, saturate} <= s_fl;
      {immediate, shift_imm, mask_begin, mask_end} <= {s_imm, s_sh, s_mb, s_me};
      {field_mask, reg_number} <= {s_fm, s_rn};
      @(posedge clk);
      issue <= 1'b0;
      #1;
      {s_fl, s_imm, s_sh, s_mb, s_me, s_fm, s_rn} = 0;
    end
  endtask
  task xr(input [5:0] op, input [31:0] va, input [31:0] vb, input [31:0] vt, input [31:0] e);
    begin
      exec(op, va, vb, vt);
      chk(result_valid, 1);
      chk(result, e);
    end
  endtask
  task t_logic;
    begin
      s_fl = 4'b0100; xr(`IEXU_OP_OR, 32'h80000000, 32'h1, 0, 32'h80000001);
      chk(cond_reg[31:28], 4'b1000);
      s_fl = 4'b0100; xr(`IEXU_OP_NAND, 32'hf0f0f0f0, 32'hff00ff00, 0, 32'h0fff0fff);
      chk(cond_reg[31:28], 4'b0100);
      chk(rf_target, 32'h80000001);
      s_fl = 4'b0100; xr(`IEXU_OP_NOR, 32'hffffffff, 0, 0, 0);
      chk(cond_reg[31:28], 4'b0010);
      xr(`IEXU_OP_ORC, 32'h1, 32'hfffffff0, 0, 32'hf);
    end
  endtask
  task t_mul;
    begin
      xr(`IEXU_OP_MULHW, 32'h80000000, 32'h2, 0, 32'hffffffff);
      xr(`IEXU_OP_MULHWU, 32'h80000000, 32'h2, 0, 32'h1);
      s_fl = 4'b0010; xr(`IEXU_OP_MULLW, 32'h10000, 32'h10000, 0, 0);
      chk(fixed_exception_reg[31:30], 2'b11);
      s_imm = 16'hfff0; xr(`IEXU_OP_MULLI, 32'h12345678, 0, 0, 32'hdcba9880);
      xr(`IEXU_OP_MULCHW, 32'h7777fffe, 32'h00039999, 0, 32'hfffffffa);
      s_fl = 4'b1000; xr(`IEXU_OP_MULCHW, 32'h7777fffe, 32'h00039999, 0, 32'h2fffa);
      xr(`IEXU_OP_MULHHW, 32'hfffe7777, 32'h00039999, 0, 32'hfffffffa);
      xr(`IEXU_OP_MULLHW, 32'h7777fffe, 32'h99990003, 0, 32'hfffffffa);
      xr(`IEXU_OP_NMACCHW, 32'hfffe, 32'h30000, 32'h7fffffff, 32'h80000005);
      s_fl = 4'b0001; xr(`IEXU_OP_NMACCHW, 32'hfffe, 32'h30000, 32'h7fffffff, 32'h7fffffff);
      xr(`IEXU_OP_NMACHHW, 32'h20000, 32'h30000, 32'h80000002, 32'h7ffffffc);
      s_fl = 4'b0001; xr(`IEXU_OP_NMACHHW, 32'h20000, 32'h30000, 32'h80000002, 32'h80000000);
      s_fl = 4'b0010; xr(`IEXU_OP_NEG, 32'h5, 0, 0, 32'hfffffffb);
      chk(fixed_exception_reg[30], 0);
      s_fl = 4'b0010; xr(`IEXU_OP_NEG, 32'h80000000, 0, 0, 32'h80000000);
      chk(fixed_exception_reg[31:30], 2'b11);
    end
  endtask
  task t_rot;
    begin
      s_fl = 4'b0100; xr(`IEXU_OP_OR, 0, 0, 0, 0);
      chk(cond_reg[31:28], 4'b0011);
      s_sh = 4; s_me = 31; xr(`IEXU_OP_RLWINM, 32'h12345678, 0, 0, 32'h23456781);
      s_sh = 4; s_mb = 28; s_me = 3; xr(`IEXU_OP_RLWINM, 32'h12345678, 0, 0, 32'h20000001);
      s_mb = 24; s_me = 31; xr(`IEXU_OP_RLWNM, 32'h12345678, 32'hffffffe4, 0, 32'h81);
      s_sh = 4; s_mb = 24; s_me = 31;
      xr(`IEXU_OP_RLWIMI, 32'h12345678, 0, 32'haaaaaaaa, 32'haaaaaa81);
      s_sh = 8; xr(`IEXU_OP_ROTRWI, 32'h12345678, 0, 0, 32'h78123456);
      xr(`IEXU_OP_SLW, 32'h80000001, 32'h1, 0, 32'h2);
      xr(`IEXU_OP_SLW, 32'hffffffff, 32'h24, 0, 0);
      xr(`IEXU_OP_SRAW, 32'h80000001, 32'h4, 0, 32'hf8000000);
      chk(fixed_exception_reg[29], 1);
      xr(`IEXU_OP_SRAW, 32'h80000000, 32'h4, 0, 32'hf8000000);
      chk(fixed_exception_reg[29], 0);
      xr(`IEXU_OP_SRAW, 32'h80000001, 32'h20, 0, 32'hffffffff);
      chk(fixed_exception_reg[29], 1);
      xr(`IEXU_OP_SRAW, 32'h7fffffff, 32'h24, 0, 0);
      chk(fixed_exception_reg[29], 0);
    end
  endtask
  task t_moves;
    begin
      s_fm = 8'hff; exec(`IEXU_OP_MTCRF, 32'h12345678);
      chk(cond_reg, 32'h12345678);
      s_fm = 8'h81; exec(`IEXU_OP_MTCRF, 32'habcdef12);
      chk(cond_reg, 32'ha2345672);
      s_rn = `IEXU_SPR_SAVE_RESTORE_0; exec(`IEXU_OP_MTSPR, 32'h100);
      chk({save_restore_0[30:0], spr_write}, 32'h200);
      s_rn = `IEXU_SPR_SAVE_RESTORE_0; xr(`IEXU_OP_MFSPR, 0, 0, 0, 32'h100);
      s_rn = 10'h110; exec(`IEXU_OP_MTSPR, 32'h13572468);
      chk({spr_write, spr_number, spr_wdata[20:0]}, {11'h510, 21'h172468});
      s_rn = 10'h110; xr(`IEXU_OP_MFSPR, 0, 0, 0, 32'h13572468);
      s_rn = `IEXU_TBR_UPPER; xr(`IEXU_OP_MFTB, 0, 0, 0, 32'h01234567);
      s_rn = 10'h10c; xr(`IEXU_OP_MFTB, 0, 0, 0, 32'h89abcdef);
      s_rn = 10'h0a0; exec(`IEXU_OP_MTDCR, 32'h2468ace0);
      chk({dcr_write, dcr_number, dcr_wdata[20:0]}, {11'h4a0, 21'h08ace0});
      exec(`IEXU_OP_MTMSR, 32'hffffffff);
      chk(machine_state, 32'hffffffff);
      s_rn = `IEXU_SPR_VPREFIX; exec(`IEXU_OP_MTSPR, 32'hfff12345);
      exec(`IEXU_OP_SYSCALL, 0);
      chk({pc_load, new_pc[30:0]}, 32'hfff10c00);
      chk(save_restore_0 ^ save_restore_1, 32'hffffdfff);
      chk(machine_state, 32'hfff93fcf);
      exec(`IEXU_OP_NOP, 32'h1, 32'h1);
      chk({result_valid, machine_state[30:0]}, 32'h7ff93fcf);
      exec(`IEXU_OP_RFI, 0);
      chk({new_pc, machine_state}, {32'h2000, 32'hffffffff});
      s_rn = `IEXU_SPR_SAVE_RESTORE_2; exec(`IEXU_OP_MTSPR, 32'h3000);
      s_rn = `IEXU_SPR_SAVE_RESTORE_3; exec(`IEXU_OP_MTSPR, 32'ha5a5);
      exec(`IEXU_OP_RFCI, 0);
      chk({new_pc[15:0], machine_state[15:0]}, 32'h3000a5a5);
    end
  endtask
  task end_sim;
    begin
      if (errors == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_logic;
    t_mul;
    t_rot;
    t_moves;
    end_sim;
  end
  // watchdog well beyond the roughly 100 cycles the run needs
  initial begin
    #20000;
    errors = errors + 1;
    end_sim;
  end
endmodule

/* File: verification/iexu_regfile_model.sv */
// register-file and special-register model at the far side of the execution unit
`timescale 1ns/1ns
module iexu_regfile_model (
  input  wire        clk,
  input  wire        rstn,
  input  wire [31:0] result,
  input  wire        result_valid,
  input  wire [31:0] spr_wdata,
  input  wire        spr_write,
  output reg  [31:0] spr_rdata,
  output reg  [31:0] target
);
  // target takes each valid result; unwritten special register reads a pattern, not zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spr_rdata <= 32'h5a5a5a5a;
      target    <= 32'h0;
    end else begin
      if (result_valid)
        target <= result;
      if (spr_write)
        spr_rdata <= spr_wdata;
    end
  end
endmodule

/* File: verilog/iexu_defs.vh */
// constants for the integer execution unit
`ifndef IEXU_DEFS_VH
`define IEXU_DEFS_VH
// operation codes
`define IEXU_OP_NOP      6'h00
`define IEXU_OP_MULHW    6'h01
`define IEXU_OP_MULHWU   6'h02
`define IEXU_OP_MULLW    6'h03
`define IEXU_OP_MULLI    6'h04
`define IEXU_OP_MULCHW   6'h05
`define IEXU_OP_MULHHW   6'h06
`define IEXU_OP_MULLHW   6'h07
`define IEXU_OP_NMACCHW  6'h08
`define IEXU_OP_NMACHHW  6'h09
`define IEXU_OP_NAND     6'h0a
`define IEXU_OP_NOR      6'h0b
`define IEXU_OP_OR       6'h0c
`define IEXU_OP_ORC      6'h0d
`define IEXU_OP_NEG      6'h0e
`define IEXU_OP_RLWINM   6'h0f
`define IEXU_OP_RLWNM    6'h10
`define IEXU_OP_RLWIMI   6'h11
`define IEXU_OP_SLW      6'h12
`define IEXU_OP_SRAW     6'h13
`define IEXU_OP_ROTRWI   6'h14
`define IEXU_OP_MTCRF    6'h15
`define IEXU_OP_MFSPR    6'h16
`define IEXU_OP_MTSPR    6'h17
`define IEXU_OP_MFTB     6'h18
`define IEXU_OP_MTDCR    6'h19
`define IEXU_OP_MTMSR    6'h1a
`define IEXU_OP_RFI      6'h1b
`define IEXU_OP_RFCI     6'h1c
`define IEXU_OP_SYSCALL  6'h1d
`define IEXU_OP_ORI      6'h1e
// special register numbers handled locally
`define IEXU_SPR_SAVE_RESTORE_0    10'h01a
`define IEXU_SPR_SAVE_RESTORE_1    10'h01b
`define IEXU_SPR_SAVE_RESTORE_2    10'h3de
`define IEXU_SPR_SAVE_RESTORE_3    10'h3df
`define IEXU_SPR_VPREFIX 10'h3d6
`define IEXU_TBR_UPPER   10'h10d
// machine-state bits cleared by a system call (msb-first numbering 13,14,16,17,26,27)
`define IEXU_MSR_SC_CLR  32'h0006c030
`define IEXU_SC_OFFSET   16'h0c00
// word constants
`define IEXU_ZERO        32'h00000000
`define IEXU_ONES        32'hffffffff
`define IEXU_MAX_POS     32'h7fffffff
`define IEXU_MIN_NEG     32'h80000000
`define IEXU_WORD_BITS   6'h20
`endif

/* File: verilog/iexu_integer_exec_unit.v */
// integer execution datapath: multiplies, logic, rotates, shifts, moves, returns
`timescale 1ns/1ns
`include "iexu_defs.vh"

// Behaviour
// - high-word multiply writes upper 32 bits of signed or unsigned 64-bit product.
// - low-word multiply writes lower 32 bits; overflow forms update ov and so.
// - multiply-immediate forms 48-bit product with signed immediate, writes bits 16..47.
// - halfword multiplies pick low-high, high-high or low-low halves, signed or unsigned.
// - negative multiply-accumulate adds negated product to target in 33 bits.
// - saturating form clamps to most positive or negative value on overflow.
// - logic unit does nand, nor, or, or-with-complement; record forms update field zero.
// - negate is inversion plus one; overflow forms update ov and so.
// - rotate-immediate-and-mask rotates left by immediate then ands mask.
// - rotate-by-register takes count from low five bits of second source.
// - rotate-and-insert replaces only masked destination bits.
// - left shift zero fills, gives zero when count bit 26 set.
// - algebraic right shift sign fills, carry when negative and ones lost.
// - rotate-right-immediate is rotate left by 32 minus count, full mask.
// - special-register moves copy between target and the numbered special register.
// - time-base read returns lower or upper half by register number.
// - writes device-control register by number; machine-state move loads from source.
// - interrupt returns reload pc and state from save pair 0/1 or 2/3.
// - system call saves state and pc, vectors to prefix plus 0c00, clears bits.
// - preferred no-op (or-immediate 0,0,0) changes no architectural state.
module iexu_integer_exec_unit (
  input  wire        clk,
  input  wire        rstn,
  input  wire        issue,
  input  wire [5:0]  opcode,
  input  wire        is_unsigned,
  input  wire        record_form,
  input  wire        ovf_enable,
  input  wire        saturate,
  input  wire [31:0] src_a,
  input  wire [31:0] src_b,
  input  wire [31:0] src_t,
  input  wire [15:0] immediate,
  input  wire [4:0]  shift_imm,
  input  wire [4:0]  mask_begin,
  input  wire [4:0]  mask_end,
  input  wire [7:0]  field_mask,
  input  wire [9:0]  reg_number,
  input  wire [31:0] pc_in,
  input  wire [31:0] spr_rdata,
  input  wire [63:0] timebase,
  output reg  [31:0] result,
  output reg         result_valid,
  output reg  [31:0] cond_reg,
  output reg  [31:0] fixed_exception_reg,
  output reg  [31:0] machine_state,
  output reg  [31:0] save_restore_0,
  output reg  [31:0] save_restore_1,
  output reg  [31:0] save_restore_2,
  output reg  [31:0] save_restore_3,
  output reg  [31:0] vector_prefix,
  output reg  [31:0] new_pc,
  output reg         pc_load,
  output reg  [31:0] spr_wdata,
  output reg  [9:0]  spr_number,
  output reg         spr_write,
  output reg  [31:0] dcr_wdata,
  output reg  [9:0]  dcr_number,
  output reg         dcr_write
);

  // --------------------------------------------------------------------
  // mask and rotate helpers (bit 0 is the msb in the mask numbering)
  // --------------------------------------------------------------------
  function [31:0] mask_fn;
    input [4:0] mb;
    input [4:0] me;
    integer i;
    reg     ge;
    reg     le;
    begin
      mask_fn = `IEXU_ZERO;
      for (i = 0; i < 32; i = i + 1) begin
        ge = (i[4:0] >= mb);
        le = (i[4:0] <= me);
        // wrap-around mask when begin lies past end
        mask_fn[31 - i] = (mb <= me) ? (ge & le) : (ge | le);
      end
    end
  endfunction

  function [31:0] rotl;
    input [31:0] v;
    input [4:0]  n;
    reg   [63:0] d;
    begin
      d    = {v, v} << n;
      rotl = d[63:32];
    end
  endfunction

  // --------------------------------------------------------------------
  // multiplier paths
  // --------------------------------------------------------------------
  wire [63:0] prod_s  = $signed(src_a) * $signed(src_b);
  wire [63:0] prod_u  = src_a * src_b;
  wire [47:0] prod_im = $signed(src_a) * $signed(immediate);
  wire        hw_lo_a = (opcode != `IEXU_OP_MULHHW) && (opcode != `IEXU_OP_NMACHHW);
  wire        hw_hi_b = (opcode != `IEXU_OP_MULLHW);
  wire [15:0] half_a  = hw_lo_a ? src_a[15:0] : src_a[31:16];
  wire [15:0] half_b  = hw_hi_b ? src_b[31:16] : src_b[15:0];
  wire [31:0] hprod_s = $signed(half_a) * $signed(half_b);
  wire [31:0] hprod_u = half_a * half_b;
  wire [31:0] hprod   = is_unsigned ? hprod_u : hprod_s;

  // negated product accumulate in 33 bits
  wire [31:0] nprod   = ~hprod_s + 32'h00000001;
  wire [32:0] nsum    = {nprod[31], nprod} + {src_t[31], src_t};
  wire        nmac_ov = (nprod[31] == src_t[31]) && (src_t[31] != nsum[31]);
  wire [31:0] nmac_r  = (saturate && nmac_ov) ?
                        (src_t[31] ? `IEXU_MIN_NEG : `IEXU_MAX_POS) : nsum[31:0];

  // low-word overflow: upper half not a sign extension of the low half
  wire        mullw_ov = (prod_s[63:32] != {32{prod_s[31]}});
  wire [31:0] neg_r    = ~src_a + 32'h00000001;
  wire        neg_ov   = (src_a == `IEXU_MIN_NEG);

  // --------------------------------------------------------------------
  // rotate and shift paths
  // --------------------------------------------------------------------
  wire [4:0]  rb_cnt   = src_b[4:0];
  wire        rb_big   = src_b[5];
  wire [4:0]  rot_back = 5'h00 - rb_cnt;   // 32 - n modulo 32
  wire [4:0]  rotr_cnt = 5'h00 - shift_imm;
  wire [31:0] rot_imm  = rotl(src_a, shift_imm);
  wire [31:0] rot_reg  = rotl(src_a, rb_cnt);
  wire [31:0] rot_sra  = rotl(src_a, rot_back);
  wire [31:0] m_user   = mask_fn(mask_begin, mask_end);
  wire [31:0] m_slw    = rb_big ? `IEXU_ZERO : mask_fn(5'h00, 5'h1f - rb_cnt);
  wire [31:0] m_sra    = rb_big ? `IEXU_ZERO : mask_fn(rb_cnt, 5'h1f);
  wire        sgn      = src_a[31];
  wire [31:0] sra_r    = (rot_sra & m_sra) | ({32{sgn}} & ~m_sra);
  wire        sra_ca   = sgn && ((rot_sra & ~m_sra) != `IEXU_ZERO);

  // condition move mask, one nibble per field-mask bit
  wire [31:0] cr_mask;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_crm
      assign cr_mask[31 - 4*g -: 4] = {4{field_mask[7 - g]}};
    end
  endgenerate

  // --------------------------------------------------------------------
  // result select
  // --------------------------------------------------------------------
  reg [31:0] next_result;
  reg        next_wr;
  reg        next_ov;
  reg        next_ov_upd;
  reg        next_ca_upd;
  always @* begin
    next_result = `IEXU_ZERO;
    next_wr     = 1'b1;
    next_ov     = 1'b0;
    next_ov_upd = 1'b0;
    next_ca_upd = 1'b0;
    case (opcode)
      `IEXU_OP_MULHW:   next_result = prod_s[63:32];
      `IEXU_OP_MULHWU:  next_result = prod_u[63:32];
      `IEXU_OP_MULLW: begin
        next_result = prod_s[31:0];
        next_ov     = mullw_ov;
        next_ov_upd = ovf_enable;
      end
      // msb-first bits 16..47 of the 48-bit product are its low word
      `IEXU_OP_MULLI:   next_result = prod_im[31:0];
      `IEXU_OP_MULCHW,
      `IEXU_OP_MULHHW,
      `IEXU_OP_MULLHW:  next_result = hprod;
      `IEXU_OP_NMACCHW,
      `IEXU_OP_NMACHHW: begin
        next_result = nmac_r;
        next_ov     = nmac_ov;
        next_ov_upd = ovf_enable;
      end
      `IEXU_OP_NAND:    next_result = ~(src_a & src_b);
      `IEXU_OP_NOR:     next_result = ~(src_a | src_b);
      `IEXU_OP_OR:      next_result = src_a | src_b;
      `IEXU_OP_ORC:     next_result = src_a | ~src_b;
      `IEXU_OP_NEG: begin
        next_result = neg_r;
        next_ov     = neg_ov;
        next_ov_upd = ovf_enable;
      end
      `IEXU_OP_RLWINM:  next_result = rot_imm & m_user;
      `IEXU_OP_RLWNM:   next_result = rot_reg & m_user;
      `IEXU_OP_RLWIMI:  next_result = (rot_imm & m_user) | (src_t & ~m_user);
      `IEXU_OP_SLW:     next_result = rot_reg & m_slw;
      `IEXU_OP_SRAW: begin
        next_result = sra_r;
        next_ca_upd = 1'b1;
      end
      `IEXU_OP_ROTRWI:  next_result = rotl(src_a, rotr_cnt);
      `IEXU_OP_ORI:     next_result = src_a | {16'h0000, immediate};
      `IEXU_OP_MFSPR: begin
        // locally held save registers and vector prefix answer directly, others from outside
        case (reg_number)
          `IEXU_SPR_SAVE_RESTORE_0:    next_result = save_restore_0;
          `IEXU_SPR_SAVE_RESTORE_1:    next_result = save_restore_1;
          `IEXU_SPR_SAVE_RESTORE_2:    next_result = save_restore_2;
          `IEXU_SPR_SAVE_RESTORE_3:    next_result = save_restore_3;
          `IEXU_SPR_VPREFIX: next_result = vector_prefix;
          default:           next_result = spr_rdata;
        endcase
      end
      `IEXU_OP_MFTB:
        next_result = (reg_number == `IEXU_TBR_UPPER) ? timebase[63:32] : timebase[31:0];
      default:          next_wr = 1'b0;
    endcase
  end

  // no-op form: or-immediate of register 0 with zero, nothing retires
  wire is_nop = (opcode == `IEXU_OP_NOP);

  // field zero value for record forms
  wire [3:0] cr0_val = {next_result[31],
                        ~next_result[31] && (next_result != `IEXU_ZERO),
                        (next_result == `IEXU_ZERO),
                        fixed_exception_reg[31] | (next_ov_upd & next_ov)};

  // --------------------------------------------------------------------
  // architectural state update
  // --------------------------------------------------------------------
  // every output is a flop so the register file sees a clean write port
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result              <= `IEXU_ZERO;
      result_valid        <= 1'b0;
      cond_reg            <= `IEXU_ZERO;
      fixed_exception_reg <= `IEXU_ZERO;
      machine_state       <= `IEXU_ZERO;
      save_restore_0      <= `IEXU_ZERO;
      save_restore_1      <= `IEXU_ZERO;
      save_restore_2      <= `IEXU_ZERO;
      save_restore_3      <= `IEXU_ZERO;
      vector_prefix       <= `IEXU_ZERO;
      new_pc              <= `IEXU_ZERO;
      pc_load             <= 1'b0;
      spr_wdata           <= `IEXU_ZERO;
      spr_number          <= 10'h000;
      spr_write           <= 1'b0;
      dcr_wdata           <= `IEXU_ZERO;
      dcr_number          <= 10'h000;
      dcr_write           <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      pc_load      <= 1'b0;
      spr_write    <= 1'b0;
      dcr_write    <= 1'b0;
      if (issue && !is_nop) begin
        result       <= next_result;
        result_valid <= next_wr;
        if (next_ov_upd) begin
          // summary overflow is sticky, overflow follows each update
          fixed_exception_reg[30] <= next_ov;
          fixed_exception_reg[31] <= fixed_exception_reg[31] | next_ov;
        end
        if (next_ca_upd)
          fixed_exception_reg[29] <= sra_ca;
        if (record_form && next_wr)
          cond_reg[31:28] <= cr0_val;
        case (opcode)
          `IEXU_OP_MTCRF:
            cond_reg <= (src_a & cr_mask) | (cond_reg & ~cr_mask);
          `IEXU_OP_MTSPR: begin
            case (reg_number)
              `IEXU_SPR_SAVE_RESTORE_0:    save_restore_0 <= src_a;
              `IEXU_SPR_SAVE_RESTORE_1:    save_restore_1 <= src_a;
              `IEXU_SPR_SAVE_RESTORE_2:    save_restore_2 <= src_a;
              `IEXU_SPR_SAVE_RESTORE_3:    save_restore_3 <= src_a;
              `IEXU_SPR_VPREFIX: vector_prefix  <= src_a;
              default: begin
                spr_wdata  <= src_a;
                spr_number <= reg_number;
                spr_write  <= 1'b1;
              end
            endcase
          end
          `IEXU_OP_MTDCR: begin
            dcr_wdata  <= src_a;
            dcr_number <= reg_number;
            dcr_write  <= 1'b1;
          end
          `IEXU_OP_MTMSR:   machine_state <= src_a;
          `IEXU_OP_RFI: begin
            new_pc        <= save_restore_0;
            machine_state <= save_restore_1;
            pc_load       <= 1'b1;
          end
          `IEXU_OP_RFCI: begin
            new_pc        <= save_restore_2;
            machine_state <= save_restore_3;
            pc_load       <= 1'b1;
          end
          `IEXU_OP_SYSCALL: begin
            save_restore_1 <= machine_state;
            save_restore_0 <= pc_in;
            new_pc         <= {vector_prefix[31:16], `IEXU_SC_OFFSET};
            machine_state  <= machine_state & ~`IEXU_MSR_SC_CLR;
            pc_load        <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

endmodule
